// ===== hdl/ast_tx.sv
// Asynchronous serial transmitter: holding buffer, shifter, baud divider, pin control.
// Assumes synchronous inputs on clk_sys and one-cycle register strobes.
// Operation
// - Line idles at mark; frame is start space, data bits, stop mark.
// - Data bits leave least significant bit first.
// - Every bit holds the line exactly one bit period.
// - Bit period comes from an 8-bit or 16-bit system clock divider.
// - Same format and rate as receiver; no hardware parity.
// - Transmit only when enabled, async selected and port enabled.
// - Port enable together with transmit enable forces the serial pin to drive as output.
// - Disabled transmitter releases the pin for general use.
// - Buffer write starts sending; empty shifter loads at once.
// - Busy shifter: character waits, loads right after the stop bit.
// - Buffer-empty flag set while enabled and the buffer holds nothing.
// - Setting transmit enable sets the buffer-empty flag at once.
// - Buffer-empty flag valid only two cycles after a buffer write.
// - Buffer-empty flag is read-only to software.
// - Flag tracks buffer regardless of its interrupt enable.
// - Shifter-empty status clears on load, sets after last bit out.
// - Shifter-empty drives no interrupt; shifter is not software visible.
// - Polarity bit zero is high-true; one inverts idle and all bits.
// - Nine-bit select sends nine data bits, ninth bit last.
// - Ninth bit is taken with the low byte at the buffer write.
module ast_tx
   import ast_pkg::*;
(
   input  wire logic       clk_sys,   // System clock, 40 MHz
   input  wire logic       rst,       // Synchronous reset, active high
   input  wire ast_req_t   reg_req,   // Register request
   output      logic [7:0] reg_rdata, // Read data, cycle after read strobe
   output      ast_pin_t   tx_pin,    // Serial out pin drive and enable
   output      logic       tx_irq     // Buffer-empty interrupt request
);

   // Software-visible control
   logic [7:0]  tsc_ff;
   logic [7:0]  rsc_ff;
   logic [7:0]  bc_ff;
   logic [7:0]  div_lo_ff;
   logic [7:0]  div_hi_ff;
   logic        irq_en_ff;
   // Holding buffer and shifter
   logic [8:0]  hold_ff;
   logic        hold_full_ff;
   logic [8:0]  shift_ff;
   logic [3:0]  bit_cnt_ff;
   logic [15:0] baud_cnt_ff;
   ast_state_t  state_ff;
   logic        flag_ff;
   logic [1:0]  settle_ff;
   logic [7:0]  rdata_ff;
   ast_pin_t    pin_ff;
   logic        irq_ff;

   logic [7:0]  nxt_rdata;
   logic [15:0] nxt_baud_cnt;
   ast_state_t  nxt_state;
   logic [8:0]  nxt_shift;
   logic [3:0]  nxt_bit_cnt;
   logic        nxt_hold_full;
   logic        nxt_flag;

   // Decoded request
   wire wr_tsc  = reg_req.wr && reg_req.addr == ADDR_TX_STATUS_CONTROL;
   wire wr_rsc  = reg_req.wr && reg_req.addr == ADDR_RX_STATUS_CONTROL;
   wire wr_bc   = reg_req.wr && reg_req.addr == ADDR_BAUD_CONTROL;
   wire wr_lo   = reg_req.wr && reg_req.addr == ADDR_BAUD_LOW;
   wire wr_hi   = reg_req.wr && reg_req.addr == ADDR_BAUD_HIGH;
   wire wr_hold = reg_req.wr && reg_req.addr == ADDR_HOLDING_BUFFER;
   wire wr_irq  = reg_req.wr && reg_req.addr == ADDR_IRQ_CONTROL;

   // Enable and format controls
   wire port_en   = rsc_ff[RSC_PORT_ENABLE];
   wire tx_en     = tsc_ff[TSC_TRANSMIT_ENABLE];
   wire tx_active = tx_en && !tsc_ff[TSC_SYNC_SELECT] && port_en;
   wire nine_bit  = tsc_ff[TSC_NINE_BIT_SELECT];
   wire invert    = bc_ff[BC_TX_POLARITY_INV];
   wire [3:0] data_bits = nine_bit ? DATA_BITS_9 : DATA_BITS_8;
   wire shifter_empty = state_ff == AST_IDLE;
   wire enable_rise = wr_tsc && reg_req.wdata[TSC_TRANSMIT_ENABLE] && !tx_en;

   // Divider: 8-bit uses low byte only, 16-bit uses the pair
   wire [15:0] div_val = bc_ff[BC_BAUD_16BIT] ? {div_hi_ff, div_lo_ff}
                                              : {8'h00, div_lo_ff};
   wire bit_tick = baud_cnt_ff == div_val;

   // Holding buffer loads into shifter when idle, or at end of stop bit
   wire stop_end = state_ff == AST_STOP && bit_tick;
   wire can_load = hold_full_ff && tx_active && (shifter_empty || stop_end);

   // Read mux; shifter itself has no address
   function automatic logic [7:0] tsc_view(input logic [7:0] r, input logic e);
      logic [7:0] v;
      v = r;
      v[TSC_SHIFTER_EMPTY] = e;
      return v;
   endfunction

   always_comb begin
      nxt_rdata = 8'h00;
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            ADDR_TX_STATUS_CONTROL: nxt_rdata = tsc_view(tsc_ff, shifter_empty);
            ADDR_RX_STATUS_CONTROL: nxt_rdata = rsc_ff;
            ADDR_BAUD_CONTROL:      nxt_rdata = bc_ff;
            ADDR_BAUD_LOW:          nxt_rdata = div_lo_ff;
            ADDR_BAUD_HIGH:         nxt_rdata = div_hi_ff;
            ADDR_IRQ_CONTROL:       nxt_rdata = {6'h00, irq_en_ff, flag_ff};
            default:                nxt_rdata = 8'h00;
         endcase
      end
   end

   // Frame sequencer
   always_comb begin
      nxt_state    = state_ff;
      nxt_shift    = shift_ff;
      nxt_bit_cnt  = bit_cnt_ff;
      nxt_baud_cnt = bit_tick ? 16'h0000 : baud_cnt_ff + 16'h0001;
      unique case (state_ff)
         AST_IDLE: begin
            nxt_baud_cnt = 16'h0000;
         end
         AST_START: begin
            if (bit_tick) begin
               nxt_state = AST_DATA;
            end
         end
         AST_DATA: begin
            if (bit_tick) begin
               nxt_shift   = {1'b0, shift_ff[8:1]};
               nxt_bit_cnt = bit_cnt_ff + 4'h1;
               if (bit_cnt_ff == data_bits - 4'h1) begin
                  nxt_state = AST_STOP;
               end
            end
         end
         AST_STOP: begin
            if (bit_tick) begin
               nxt_state = AST_IDLE;
            end
         end
      endcase
      if (can_load) begin
         nxt_shift    = hold_ff;
         nxt_bit_cnt  = 4'h0;
         nxt_baud_cnt = 16'h0000;
         nxt_state    = AST_START;
      end
      if (!tx_active) begin
         nxt_state    = AST_IDLE;
         nxt_baud_cnt = 16'h0000;
      end
   end

   // Buffer occupancy: a write arriving with a load keeps the buffer full
   always_comb begin
      nxt_hold_full = hold_full_ff;
      if (can_load) begin
         nxt_hold_full = 1'b0;
      end
      if (wr_hold && tx_active) begin
         nxt_hold_full = 1'b1;
      end
      if (!tx_en) begin
         nxt_hold_full = 1'b0;
      end
   end

   // Flag follows occupancy, frozen for the settle window after a write
   always_comb begin
      nxt_flag = flag_ff;
      if (settle_ff == 2'd0) begin
         nxt_flag = tx_en && !hold_full_ff;
      end
      if (enable_rise) begin
         nxt_flag = 1'b1;
      end
   end

   // Line level: mark idle, space start, data, mark stop, optional invert
   logic line_bit;
   always_comb begin
      unique case (state_ff)
         AST_IDLE:  line_bit = MARK_LEVEL;
         AST_START: line_bit = SPACE_LEVEL;
         AST_DATA:  line_bit = shift_ff[0];
         AST_STOP:  line_bit = MARK_LEVEL;
      endcase
   end

   // Control registers; flag and shifter-empty never written by software
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tsc_ff    <= RST_TX_STATUS_CONTROL;
         rsc_ff    <= RST_RX_STATUS_CONTROL;
         bc_ff     <= RST_BAUD_CONTROL;
         div_lo_ff <= RST_BAUD_DIV;
         div_hi_ff <= RST_BAUD_DIV;
         irq_en_ff <= 1'b0;
      end else begin
         if (wr_tsc) tsc_ff <= reg_req.wdata & 8'hFD;
         if (wr_rsc) rsc_ff <= reg_req.wdata;
         if (wr_bc)  bc_ff  <= reg_req.wdata;
         if (wr_lo)  div_lo_ff <= reg_req.wdata;
         if (wr_hi)  div_hi_ff <= reg_req.wdata;
         if (wr_irq) irq_en_ff <= reg_req.wdata[IRQ_ENABLE];
      end
   end

   // Holding buffer data with ninth bit captured at the write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hold_ff <= 9'h000;
      end else if (wr_hold && tx_active) begin
         hold_ff <= {nine_bit & tsc_ff[TSC_NINTH_BIT_VALUE], reg_req.wdata};
      end
   end

   // Shifter state
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_ff     <= AST_IDLE;
         shift_ff     <= 9'h000;
         bit_cnt_ff   <= 4'h0;
         baud_cnt_ff  <= 16'h0000;
         hold_full_ff <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         shift_ff     <= nxt_shift;
         bit_cnt_ff   <= nxt_bit_cnt;
         baud_cnt_ff  <= nxt_baud_cnt;
         hold_full_ff <= nxt_hold_full;
      end
   end

   // Flag and settle window
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flag_ff   <= 1'b0;
         settle_ff <= 2'd0;
      end else begin
         flag_ff   <= nxt_flag;
         settle_ff <= wr_hold ? 2'(FLAG_SETTLE_CYCLES - 1)
                              : (settle_ff != 2'd0 ? settle_ff - 2'd1 : 2'd0);
      end
   end

   // Registered outputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_ff <= 8'h00;
         pin_ff   <= '{out: MARK_LEVEL, oe: 1'b0};
         irq_ff   <= 1'b0;
      end else begin
         rdata_ff   <= nxt_rdata;
         pin_ff.out <= line_bit ^ invert;
         pin_ff.oe  <= port_en && tx_en;
         irq_ff     <= nxt_flag && irq_en_ff;
      end
   end

   assign reg_rdata = rdata_ff;
   assign tx_pin    = pin_ff;
   assign tx_irq    = irq_ff;

endmodule

// ===== hdl/ast_pkg.sv
// Package for the asynchronous serial transmitter: register map, fields, timing.
// Assumes a single 40 MHz system clock and a plain strobe register port.
package ast_pkg;
   // Register offsets (byte-free index on the plain port)
   localparam logic [2:0] ADDR_TX_STATUS_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_RX_STATUS_CONTROL = 3'h1;
   localparam logic [2:0] ADDR_BAUD_CONTROL      = 3'h2;
   localparam logic [2:0] ADDR_BAUD_LOW          = 3'h3;
   localparam logic [2:0] ADDR_BAUD_HIGH         = 3'h4;
   localparam logic [2:0] ADDR_HOLDING_BUFFER    = 3'h5;
   localparam logic [2:0] ADDR_IRQ_CONTROL       = 3'h6;
   // tx_status_control fields
   localparam int TSC_NINE_BIT_SELECT  = 6;
   localparam int TSC_TRANSMIT_ENABLE  = 5;
   localparam int TSC_SYNC_SELECT      = 4;
   localparam int TSC_SHIFTER_EMPTY    = 1;
   localparam int TSC_NINTH_BIT_VALUE  = 0;
   // rx_status_control fields
   localparam int RSC_PORT_ENABLE      = 7;
   // baud_control fields
   localparam int BC_TX_POLARITY_INV   = 4;
   localparam int BC_BAUD_16BIT        = 3;
   // irq control fields
   localparam int IRQ_BUFFER_EMPTY     = 0;
   localparam int IRQ_ENABLE           = 1;
   // Reset values
   localparam logic [7:0] RST_TX_STATUS_CONTROL = 8'h02;
   localparam logic [7:0] RST_RX_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] RST_BAUD_CONTROL      = 8'h00;
   localparam logic [7:0] RST_BAUD_DIV          = 8'h00;
   // Frame shape: start + up to nine data + one stop
   localparam logic [3:0] DATA_BITS_8 = 4'h8;
   localparam logic [3:0] DATA_BITS_9 = 4'h9;
   // Holding-buffer flag settles two instruction cycles after a write
   localparam int FLAG_SETTLE_CYCLES = 2;
   localparam logic MARK_LEVEL  = 1'b1;
   localparam logic SPACE_LEVEL = 1'b0;

   typedef enum {
      AST_IDLE,
      AST_START,
      AST_DATA,
      AST_STOP
   } ast_state_t;

   // Register port request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } ast_req_t;

   // Serial pin drive
   typedef struct packed {
      logic out;
      logic oe;
   } ast_pin_t;
endpackage

// ===== verification/ast_rx_model.sv
// Far-end receiver model: samples the serial line at mid-bit.
// Assumes the bench gives it polarity, character length and bit period.
module ast_rx_model (
   input  wire logic       clk_sys,  // Bench clock
   input  wire logic       line,     // Serial line level
   input  wire logic       inv,      // Line is low-true
   input  wire logic       nine,     // Nine data bits
   input  wire logic [7:0] period,   // Clocks per bit
   output      logic       rx_valid, // One-cycle character strobe
   output      logic [9:0] rx_data   // Stop bit, then data bits
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] sh;
   int         i;
   initial rx_valid = 1'b0;
   initial rx_data = '0;
   // Hunt a start, confirm it at mid-bit, then sample each bit once
   always begin
      @(posedge clk_sys);
      if ((line ^ inv) === 1'b0) begin
         repeat (period / 2) @(posedge clk_sys);
         if ((line ^ inv) === 1'b0) begin
            sh = '0;
            for (i = 0; i < (nine ? 9 : 8); i++) begin
               repeat (period) @(posedge clk_sys);
               sh[i] = line ^ inv;
            end
            repeat (period) @(posedge clk_sys);
            sh[9] = line ^ inv;
            rx_data <= sh;
            rx_valid <= 1'b1;
            @(posedge clk_sys);
            rx_valid <= 1'b0;
         end
      end
   end
endmodule

// ===== verification/ast_tx_checker.sv
// Port-level assertions for the serial transmitter.
// Assumes it sees only the top ports; control bits are shadowed from writes.
module ast_tx_checker
   import ast_pkg::*;
(
   input wire logic       clk_sys,   // System clock
   input wire logic       rst,       // Synchronous reset
   input wire ast_req_t   reg_req,   // Register request
   input wire logic [7:0] reg_rdata, // Read data
   input wire ast_pin_t   tx_pin,    // Serial pin drive
   input wire logic       tx_irq     // Interrupt request
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       en_ff, pe_ff, sy_ff, inv_ff, ien_ff, last_ff;
   logic [7:0] dlo_ff;
   logic [6:0] quiet_ff;
   wire logic  on_w = en_ff & pe_ff;
   wire logic  wr_w = reg_req.wr;
   // Shadow of control bits and of how long the line has been still
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         {en_ff, pe_ff, sy_ff, inv_ff, ien_ff, dlo_ff, quiet_ff} <= '0;
      end else begin
         quiet_ff <= (tx_pin.out != last_ff) ? 7'd0 : quiet_ff + 7'(quiet_ff != 7'd100);
         if (wr_w && reg_req.addr == ADDR_TX_STATUS_CONTROL) begin
            {en_ff, sy_ff} <= reg_req.wdata[5:4];
         end
         if (wr_w && reg_req.addr == ADDR_RX_STATUS_CONTROL) pe_ff <= reg_req.wdata[7];
         if (wr_w && reg_req.addr == ADDR_BAUD_CONTROL) inv_ff <= reg_req.wdata[4];
         if (wr_w && reg_req.addr == ADDR_BAUD_LOW) dlo_ff <= reg_req.wdata;
         if (wr_w && reg_req.addr == ADDR_IRQ_CONTROL) ien_ff <= reg_req.wdata[1];
      end
      last_ff <= tx_pin.out;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_idle_write;
      wr_w && reg_req.addr == ADDR_HOLDING_BUFFER && on_w && !sy_ff && quiet_ff == 7'd100;
   endsequence
   sequence s_start_space;
      ##3 tx_pin.out == inv_ff;
   endsequence
   a_reset_levels: assert property ($fell(rst) |-> tx_pin.out && !tx_pin.oe && !tx_irq)
      else $error("outputs wrong after reset");
   a_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 8'h00)
      else $error("read data without read");
   a_hidden_read: assert property (reg_req.rd && reg_req.addr inside {3'h5, 3'h7}
      |=> reg_rdata == 8'h00) else $error("hidden place read nonzero");
   a_irq_gated: assert property (!ien_ff && !$past(ien_ff) |-> !tx_irq)
      else $error("interrupt while disabled");
   a_pin_driven: assert property (on_w && $past(on_w) && $past(on_w, 2) |-> tx_pin.oe)
      else $error("pin not driven");
   a_pin_release: assert property (!on_w && !$past(on_w) && !$past(on_w, 2) |-> !tx_pin.oe)
      else $error("pin not released");
   a_idle_level: assert property ((!on_w && $stable(inv_ff)) [*3] |-> tx_pin.out == !inv_ff)
      else $error("idle level wrong");
   a_bit_hold: assert property ($changed(tx_pin.out) && on_w && dlo_ff >= 8'h03
      |=> $stable(tx_pin.out) [*3]) else $error("bit shorter than period");
   a_start_prompt: assert property (s_idle_write |-> s_start_space)
      else $error("start bit late");
endmodule

// ===== verification/testbench.sv
// Self-checking bench: register port driver, far-end receiver, queue checks.
// Assumes ast_pkg, ast_tx, the receiver model and the checker compile first.
module testbench
   import ast_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0, rst = 1'b1, inv_m = 1'b0, nine_m = 1'b0, rd_d = 1'b0;
   logic        irq, rx_valid;
   logic [7:0]  rdata, per_m = 8'd4, rexp_q[$];
   logic [9:0]  rx_data, exp_q[$];
   logic [31:0] seed = 32'h2740_a31c;
   ast_req_t    req = '0;
   ast_pin_t    pin;
   int          n_errors = 0, check_count = 0, cyc = 0, last = 0, g, gap_q[$];
   wire logic   line = pin.oe ? pin.out : 1'b1; // Pull-up when released
   always #12.5 clk_sys = ~clk_sys;
   ast_tx u_dut (.clk_sys(clk_sys), .rst(rst), .reg_req(req), .reg_rdata(rdata),
      .tx_pin(pin), .tx_irq(irq));
   ast_rx_model u_rx (.clk_sys(clk_sys), .line(line), .inv(inv_m), .nine(nine_m),
      .period(per_m), .rx_valid(rx_valid), .rx_data(rx_data));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w);
      req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      rexp_q.push_back(e);
      bus(a, 8'h00, 1'b0);
   endtask
   task automatic idle(input int n);
      req <= '0;
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic send(input logic [8:0] d, input int gap);
      exp_q.push_back({1'b1, d});
      gap_q.push_back(gap);
      bus(ADDR_HOLDING_BUFFER, d[7:0], 1'b1);
   endtask
   task automatic drain;
      req <= '0;
      for (int k = 0; k < 3000 && exp_q.size() != 0; k++) @(posedge clk_sys);
   endtask
   // Watcher: read data, received characters, frame spacing, timeout
   always @(posedge clk_sys) begin
      cyc++;
      rd_d <= req.rd;
      if (rd_d) check({2'b00, rdata}, {2'b00, rexp_q.pop_front()}, "rdata");
      if (rx_valid) begin
         check(rx_data, exp_q.size() ? exp_q.pop_front() : 10'h000, "char");
         g = gap_q.size() ? gap_q.pop_front() : 0;
         if (g != 0) check(10'(cyc - last), 10'(g), "gap");
         last = cyc;
      end
      if (cyc == 6000) begin
         n_errors++;
         test_done;
      end
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      idle(1);
      // Reset values, hidden places, inactive transmitter
      rd(ADDR_TX_STATUS_CONTROL, RST_TX_STATUS_CONTROL);
      rd(ADDR_HOLDING_BUFFER, 8'h00);
      rd(3'h7, 8'h00);
      rd(ADDR_IRQ_CONTROL, 8'h00);
      bus(ADDR_BAUD_LOW, 8'h03, 1'b1);
      bus(ADDR_RX_STATUS_CONTROL, 8'h80, 1'b1);
      bus(ADDR_TX_STATUS_CONTROL, 8'h30, 1'b1);
      bus(ADDR_HOLDING_BUFFER, 8'h5a, 1'b1);
      bus(ADDR_TX_STATUS_CONTROL, 8'h20, 1'b1);
      bus(ADDR_IRQ_CONTROL, 8'h02, 1'b1);
      idle(3);
      rd(ADDR_IRQ_CONTROL, 8'h03);
      idle(2);
      #1 check({9'b0, pin.oe}, 10'h001, "oe");
      check({9'b0, irq}, 10'h001, "irq");
      $display("test setup done");
      // Two random characters back to back
      idle(110);
      for (int k = 0; k < 2; k++) begin
         seed = lfsr(seed);
         send({1'b0, seed[7:0]}, k * 10 * per_m);
      end
      idle(3);
      rd(ADDR_IRQ_CONTROL, 8'h02);
      rd(ADDR_TX_STATUS_CONTROL, 8'h20);
      drain;
      idle(6);
      bus(ADDR_IRQ_CONTROL, 8'h00, 1'b1);
      rd(ADDR_IRQ_CONTROL, 8'h01);
      rd(ADDR_TX_STATUS_CONTROL, 8'h22);
      idle(2);
      #1 check({9'b0, irq}, 10'h000, "irq");
      $display("test back to back done");
      // Nine-bit characters, 16-bit divider, inverted line
      bus(ADDR_BAUD_CONTROL, 8'h08, 1'b1);
      bus(ADDR_BAUD_HIGH, 8'h00, 1'b1);
      bus(ADDR_BAUD_LOW, 8'h05, 1'b1);
      per_m <= 8'd6;
      inv_m <= 1'b1;
      nine_m <= 1'b1;
      bus(ADDR_BAUD_CONTROL, 8'h18, 1'b1);
      idle(4);
      #1 check({9'b0, pin.out}, 10'h000, "idle");
      for (int m = 0; m < 2; m++) begin
         seed = lfsr(seed);
         bus(ADDR_TX_STATUS_CONTROL, 8'h60 | 8'(m), 1'b1);
         send({m[0], seed[7:0]}, m * 11 * 6);
      end
      drain;
      idle(8);
      inv_m <= 1'b0;
      bus(ADDR_BAUD_CONTROL, 8'h08, 1'b1);
      idle(4);
      $display("test nine bit done");
      // Disabled transmitter releases the pin and drops writes
      bus(ADDR_TX_STATUS_CONTROL, 8'h00, 1'b1);
      idle(3);
      bus(ADDR_HOLDING_BUFFER, 8'ha5, 1'b1);
      idle(100);
      #1 check({9'b0, pin.oe}, 10'h000, "oe");
      $display("test disable done");
      test_done;
   end
endmodule
bind ast_tx ast_tx_checker u_chk (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .tx_pin(tx_pin), .tx_irq(tx_irq));
